// file: hw/lp_defines.svh
// register offsets, field positions, reset values and link timing counts
// assumes a 32-bit register port with byte addresses on an 8-bit bus
`ifndef LP_DEFINES_SVH
`define LP_DEFINES_SVH

`define LP_ADDR_MR2        8'h00
`define LP_ADDR_MR4        8'h04
`define LP_ADDR_MR5        8'h08
`define LP_ADDR_STATUS     8'h0c

`define LP_MR2_SR_LSB      6
`define LP_MR4_CAL_LSB     6
`define LP_MR4_ABORT_BIT   9
`define LP_MR5_PAR_LSB     0
`define LP_MR5_ODTOFF_BIT  5
`define LP_MR5_PARK_LSB    6
`define LP_ST_VIOL_BIT     7

`define LP_SR_SEL_RST      2'h0
`define LP_FIELD3_RST      3'h0

// counts in link clock edges
`define LP_CPDED_NCK       4
`define LP_XP_NCK          4
`define LP_XS_NCK          16
`define LP_XS_ABORT_NCK    8
`define LP_MPX_NCK         4

`endif

// file: hw/lp_pkg.sv
// types shared by the low-power state logic
// assumes nothing beyond a SystemVerilog compiler
package lp_pkg;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_PD_ENT  = 3'h1,
      ST_PD      = 3'h3,
      ST_PD_EXIT = 3'h2,
      ST_SR      = 3'h6,
      ST_SR_EXIT = 3'h7
   } lp_state_t;

   typedef enum logic [1:0] {
      PD_NONE      = 2'h0,
      PD_PRECHARGE = 2'h1,
      PD_ACTIVE    = 2'h2
   } pd_kind_t;

   localparam logic [1:0] RATE_NORMAL  = 2'h0;
   localparam logic [1:0] RATE_REDUCED = 2'h1;
   localparam logic [1:0] RATE_HIGH    = 2'h2;
   localparam logic [1:0] RATE_AUTO    = 2'h3;

endpackage

// file: hw/lp_link_if.sv
// decoded link events passed from the pin sampler to the state logic
// assumes both ends run on core_clk_i
`timescale 1ns/100ps
interface lp_link_if;
   logic ev;
   logic cke;
   logic cke_prev;
   logic des;
   logic nop;
   logic sre;
   logic hot;

   modport src (output ev, cke, cke_prev, des, nop, sre, hot);
   modport dst (input  ev, cke, cke_prev, des, nop, sre, hot);
endinterface

// file: hw/link_sampler.sv
// synchronises the link pins and decodes one command per link clock edge
// assumes pins are asynchronous to core_clk_i, link clock much slower
`timescale 1ns/100ps
module link_sampler (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   // pins
   input  wire logic ck_i,
   input  wire logic cke_i,
   input  wire logic cs_n_i,
   input  wire logic act_n_i,
   input  wire logic ras_n_i,
   input  wire logic cas_n_i,
   input  wire logic we_n_i,
   input  wire logic temp_hot_i,
   // decoded events
   lp_link_if.src    lk
);

   logic [7:0] meta;
   logic [7:0] pins;
   logic       ck_d;
   logic       edge_seen;

   // two flops per pin; only the second stage is looked at
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= 8'h0;
         pins <= 8'h0;
      end else if (ce_i) begin
         meta <= {temp_hot_i, we_n_i, cas_n_i, ras_n_i,
                  act_n_i, cs_n_i, cke_i, ck_i};
         pins <= meta;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ck_d <= 1'b0;
      end else if (ce_i) begin
         ck_d <= pins[0];
      end
   end

   assign edge_seen = pins[0] && !ck_d;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lk.ev       <= 1'b0;
         lk.cke      <= 1'b1;
         lk.cke_prev <= 1'b1;
         lk.des      <= 1'b1;
         lk.nop      <= 1'b0;
         lk.sre      <= 1'b0;
         lk.hot      <= 1'b0;
      end else if (ce_i) begin
         lk.ev  <= edge_seen;
         lk.hot <= pins[7];
         if (edge_seen) begin
            lk.cke_prev <= lk.cke;
            lk.cke      <= pins[1];
            lk.des      <= pins[2];
            lk.nop      <= !pins[2] && pins[3] && pins[4] &&
                           pins[5] && pins[6];
            lk.sre      <= !pins[2] && pins[3] && !pins[4] &&
                           !pins[5] && pins[6] && !pins[1];
         end
      end
   end

endmodule

// file: hw/ddr4_low_power_state_logic.sv
// low-power state logic: self-refresh rate, self-refresh exit, power-down
// assumes a register port on core_clk_i and link pins sampled by it
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "lp_defines.svh"

module ddr4_low_power_state_logic
   import lp_pkg::*;
#(
   parameter int unsigned CPDED_NCK    = `LP_CPDED_NCK,
   parameter int unsigned XP_NCK       = `LP_XP_NCK,
   parameter int unsigned XS_NCK       = `LP_XS_NCK,
   parameter int unsigned XS_ABORT_NCK = `LP_XS_ABORT_NCK,
   parameter int unsigned MPX_NCK      = `LP_MPX_NCK
) (
   // clock, reset, enable
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   // register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // link pins
   input  wire logic        ck_i,
   input  wire logic        cke_i,
   input  wire logic        cs_n_i,
   input  wire logic        act_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic        temp_hot_i,
   // core status
   input  wire logic        op_busy_i,
   input  wire logic        bank_open_i,
   input  wire logic        refresh_busy_i,
   // low-power controls
   output logic             in_pd_o,
   output logic             in_sr_o,
   output logic             low_current_o,
   output logic [1:0]       pd_kind_o,
   output logic             io_buf_en_o,
   output logic             ca_rx_en_o,
   output logic             odt_buf_en_o,
   output logic             rtt_nom_en_o,
   output logic             rtt_park_en_o,
   output logic             dll_en_o,
   output logic             cmd_ready_o,
   output logic [1:0]       sr_rate_o,
   output logic             refresh_abort_o,
   output logic [15:0]      refresh_count_o
);

   logic       rst_meta_n;
   logic       rst_n;
   lp_link_if  lk ();

   lp_state_t  state;
   logic [7:0] cnt;
   logic [7:0] mpx_cnt;
   logic [1:0] sr_sel;
   logic       abort_en;
   logic [2:0] cal_lat;
   logic [2:0] par_lat;
   logic       odt_off;
   logic [2:0] park;
   logic [1:0] sr_mode;
   logic       nop_ok;
   logic       viol;
   logic       ref_busy_d;
   logic       ref_aborted;
   logic [15:0] ref_cnt;
   logic       srx_ok;
   logic       bad_cmd;
   logic       ref_done;
   logic       pd_st;
   logic [1:0] next_rate;

   // reset released through two flops, asserted at once
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   link_sampler u_sampler (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .ce_i       (ce_i),
      .ck_i       (ck_i),
      .cke_i      (cke_i),
      .cs_n_i     (cs_n_i),
      .act_n_i    (act_n_i),
      .ras_n_i    (ras_n_i),
      .cas_n_i    (cas_n_i),
      .we_n_i     (we_n_i),
      .temp_hot_i (temp_hot_i),
      .lk         (lk.src)
   );

   // mode register shadows
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sr_sel   <= `LP_SR_SEL_RST;
         abort_en <= 1'b0;
         cal_lat  <= `LP_FIELD3_RST;
         par_lat  <= `LP_FIELD3_RST;
         odt_off  <= 1'b0;
         park     <= `LP_FIELD3_RST;
      end else if (ce_i && wr_i) begin
         if (addr_i == `LP_ADDR_MR2) begin
            sr_sel <= wdata_i[`LP_MR2_SR_LSB +: 2];
         end else if (addr_i == `LP_ADDR_MR4) begin
            abort_en <= wdata_i[`LP_MR4_ABORT_BIT];
            cal_lat  <= wdata_i[`LP_MR4_CAL_LSB +: 3];
         end else if (addr_i == `LP_ADDR_MR5) begin
            par_lat <= wdata_i[`LP_MR5_PAR_LSB +: 3];
            odt_off <= wdata_i[`LP_MR5_ODTOFF_BIT];
            park    <= wdata_i[`LP_MR5_PARK_LSB +: 3];
         end
      end
   end

   // register read, data valid the cycle after the strobe only
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= 32'h0;
      end else if (ce_i) begin
         if (!rd_i) begin
            rdata_o <= 32'h0;
         end else if (addr_i == `LP_ADDR_MR2) begin
            rdata_o <= {24'h0, sr_sel, 6'h0};
         end else if (addr_i == `LP_ADDR_MR4) begin
            rdata_o <= {22'h0, abort_en, cal_lat, 6'h0};
         end else if (addr_i == `LP_ADDR_MR5) begin
            rdata_o <= {23'h0, park, odt_off, 2'h0, par_lat};
         end else if (addr_i == `LP_ADDR_STATUS) begin
            rdata_o <= {8'h0, ref_cnt, viol, sr_rate_o,
                        pd_kind_o, state};
         end else begin
            rdata_o <= 32'h0;
         end
      end
   end

   // exit from self refresh: deselect, or no-op where entry allowed it
   assign srx_ok = lk.ev && lk.cke && (lk.des || (lk.nop && nop_ok));
   // anything but deselect in the exit delay, except window no-ops
   assign bad_cmd = lk.ev && !lk.des &&
                    !(lk.nop && nop_ok && mpx_cnt != 8'h0);

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state   <= ST_IDLE;
         cnt     <= 8'h0;
         mpx_cnt <= 8'h0;
      end else if (ce_i) begin
         case (state)
            ST_IDLE: begin
               if (lk.ev && lk.cke_prev && !lk.cke && lk.sre) begin
                  state <= ST_SR;
               end else if (lk.ev && lk.cke_prev && !lk.cke &&
                            lk.des) begin
                  state <= ST_PD_ENT;
                  cnt   <= 8'(CPDED_NCK);
               end
            end
            ST_PD_ENT: begin
               if (lk.ev && lk.cke && lk.des) begin
                  state <= ST_PD_EXIT;
                  cnt   <= 8'(XP_NCK);
               end else if (lk.ev) begin
                  if (cnt <= 8'h1) begin
                     state <= ST_PD;
                  end
                  cnt <= cnt - 8'h1;
               end
            end
            ST_PD: begin
               if (lk.ev && lk.cke && lk.des) begin
                  state <= ST_PD_EXIT;
                  cnt   <= 8'(XP_NCK);
               end
            end
            ST_PD_EXIT: begin
               if (lk.ev) begin
                  if (cnt <= 8'h1) begin
                     state <= ST_IDLE;
                  end
                  cnt <= cnt - 8'h1;
               end
            end
            ST_SR: begin
               if (srx_ok) begin
                  state   <= ST_SR_EXIT;
                  cnt     <= abort_en ? 8'(XS_ABORT_NCK) : 8'(XS_NCK);
                  mpx_cnt <= lk.nop ? 8'(MPX_NCK) : 8'h0;
               end
            end
            ST_SR_EXIT: begin
               if (lk.ev) begin
                  if (cnt <= 8'h1) begin
                     state <= ST_IDLE;
                  end
                  cnt <= cnt - 8'h1;
                  if (mpx_cnt != 8'h0) begin
                     mpx_cnt <= mpx_cnt - 8'h1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // self-refresh mode fixed at entry; later writes act on the next one
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sr_mode <= `LP_SR_SEL_RST;
         nop_ok  <= 1'b0;
      end else if (ce_i && state == ST_IDLE && lk.ev && lk.sre) begin
         sr_mode <= sr_sel;
         nop_ok  <= cal_lat == 3'h0 && par_lat == 3'h0;
      end
   end

   // sticky protocol flag; write one to clear, a new event wins
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         viol <= 1'b0;
      end else if (ce_i) begin
         if (state == ST_SR_EXIT && bad_cmd) begin
            viol <= 1'b1;
         end else if (wr_i && addr_i == `LP_ADDR_STATUS &&
                      wdata_i[`LP_ST_VIOL_BIT]) begin
            viol <= 1'b0;
         end
      end
   end

   always_comb begin
      if (sr_mode == RATE_AUTO) begin
         next_rate = lk.hot ? RATE_HIGH : RATE_NORMAL;
      end else begin
         next_rate = sr_mode;
      end
   end

   assign pd_st    = state == ST_PD_ENT || state == ST_PD;
   assign ref_done = ref_busy_d && !refresh_busy_i;

   // internal refresh counter; an aborted refresh does not count
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ref_busy_d      <= 1'b0;
         ref_aborted     <= 1'b0;
         ref_cnt         <= 16'h0;
         refresh_abort_o <= 1'b0;
      end else if (ce_i) begin
         ref_busy_d      <= refresh_busy_i;
         refresh_abort_o <= 1'b0;
         if (state == ST_SR && srx_ok && abort_en && refresh_busy_i) begin
            refresh_abort_o <= 1'b1;
            ref_aborted     <= 1'b1;
         end else if (ref_done) begin
            ref_aborted <= 1'b0;
            if (!ref_aborted) begin
               ref_cnt <= ref_cnt + 16'h1;
            end
         end
      end
   end

   // registered outputs
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         in_pd_o         <= 1'b0;
         in_sr_o         <= 1'b0;
         low_current_o   <= 1'b0;
         pd_kind_o       <= PD_NONE;
         io_buf_en_o     <= 1'b1;
         ca_rx_en_o      <= 1'b1;
         odt_buf_en_o    <= 1'b1;
         rtt_nom_en_o    <= 1'b1;
         rtt_park_en_o   <= 1'b0;
         dll_en_o        <= 1'b1;
         cmd_ready_o     <= 1'b0;
         sr_rate_o       <= RATE_NORMAL;
         refresh_count_o <= 16'h0;
      end else if (ce_i) begin
         in_pd_o         <= pd_st;
         in_sr_o         <= state == ST_SR;
         // low current only in ST_PD, once op_busy_i work has drained; refresh_busy_i is not looked at
         low_current_o   <= state == ST_PD && !op_busy_i;
         if (!pd_st) begin
            pd_kind_o <= PD_NONE;
         end else if (!op_busy_i) begin
            pd_kind_o <= bank_open_i ? PD_ACTIVE : PD_PRECHARGE;
         end
         io_buf_en_o     <= !pd_st && state != ST_SR;
         ca_rx_en_o      <= state != ST_PD && state != ST_SR;
         odt_buf_en_o    <= !(pd_st && odt_off);
         rtt_nom_en_o    <= !(pd_st && odt_off) && state != ST_SR;
         rtt_park_en_o   <= park != 3'h0 && state != ST_SR;
         dll_en_o        <= state != ST_SR;
         cmd_ready_o     <= state == ST_IDLE;
         sr_rate_o       <= next_rate;
         refresh_count_o <= ref_cnt;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n);

   property p_pd_entry;
      ce_i && state == ST_IDLE && lk.ev && lk.cke_prev && !lk.cke &&
      lk.des && !lk.sre |=> state == ST_PD_ENT;
   endproperty
   a_pd_entry: assert property (p_pd_entry)
      else $error("power-down entry not taken");

   property p_sre;
      ce_i && state == ST_IDLE && lk.ev && lk.cke_prev && lk.sre
      |=> state == ST_SR;
   endproperty
   a_sre: assert property (p_sre)
      else $error("self-refresh entry not taken");

   property p_auto_rate;
      ce_i && sr_mode == RATE_AUTO && lk.hot |=> sr_rate_o == RATE_HIGH;
   endproperty
   a_auto_rate: assert property (p_auto_rate)
      else $error("automatic mode not at high rate when hot");

   property p_manual_rate;
      ce_i && sr_mode != RATE_AUTO |=> sr_rate_o == $past(sr_mode);
   endproperty
   a_manual_rate: assert property (p_manual_rate)
      else $error("manual rate differs from mode field");

   property p_low_current;
      ce_i && state == ST_PD && op_busy_i |=> !low_current_o;
   endproperty
   a_low_current: assert property (p_low_current)
      else $error("low current before work drained");

   property p_classify;
      ce_i && state == ST_PD && !op_busy_i && bank_open_i
      |=> pd_kind_o == PD_ACTIVE;
   endproperty
   a_classify: assert property (p_classify)
      else $error("open bank not classed as active power-down");

   property p_buf_off;
      ce_i && state == ST_PD |=> !io_buf_en_o && dll_en_o && !ca_rx_en_o;
   endproperty
   a_buf_off: assert property (p_buf_off)
      else $error("buffers or DLL wrong in power-down");

   property p_odt_off;
      ce_i && pd_st && odt_off |=> !odt_buf_en_o && !rtt_nom_en_o;
   endproperty
   a_odt_off: assert property (p_odt_off)
      else $error("odt buffer left on with disable bit set");

   property p_park;
      ce_i && state == ST_PD && park != 3'h0 |=> rtt_park_en_o;
   endproperty
   a_park: assert property (p_park)
      else $error("park termination dropped in power-down");

   property p_cpded;
      ce_i && state == ST_PD_ENT |=> ca_rx_en_o;
   endproperty
   a_cpded: assert property (p_cpded)
      else $error("receivers off before entry delay");

   property p_exit;
      ce_i && state == ST_PD && lk.ev && lk.cke && lk.des
      |=> state == ST_PD_EXIT && !cmd_ready_o;
   endproperty
   a_exit: assert property (p_exit)
      else $error("power-down exit not started");

   property p_abort;
      ce_i && state == ST_SR && srx_ok && abort_en && refresh_busy_i
      |=> refresh_abort_o ##1 !refresh_abort_o || !$past(ce_i);
   endproperty
   a_abort: assert property (p_abort)
      else $error("refresh abort pulse wrong");

endmodule

// file: tb/ctrl_model.sv
// controller-side model that drives the link pins of the low-power logic
// assumes the bench calls link(); the link clock stands still between calls
`timescale 1ns/100ps
module ctrl_model (
   // link clock
   output logic ck_o,
   // command pins
   output logic cke_o,
   output logic cs_n_o,
   output logic act_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o
);
   // no odt pin modelled; termination enables are checked instead
   initial begin
      {ck_o, cke_o, cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o} = 7'h3f;
   end

   // cmd 0 deselect, 1 no-op, 2 self-refresh entry; one 200 ns link period
   task automatic link(input int n, input logic cke, input logic [1:0] cmd);
      for (int i = 0; i < n; i++) begin
         cke_o   <= cke;
         cs_n_o  <= (cmd == 2'h0);
         act_n_o <= 1'b1;
         we_n_o  <= 1'b1;
         // ras_n and cas_n toggle on deselect so no stale value looks valid
         ras_n_o <= (cmd == 2'h0) ? ~ras_n_o : (cmd != 2'h2);
         cas_n_o <= (cmd == 2'h0) ? ~cas_n_o : (cmd != 2'h2);
         #100 ck_o <= 1'b1;
         #100 ck_o <= 1'b0;
      end
   endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the low-power state logic
// assumes ctrl_model drives the link pins; short link counts are used
`timescale 1ns/100ps
module tb;
   import lp_pkg::*;
   typedef struct {logic [1:0] sel; logic hot; logic [1:0] rate;} row_t;
   logic        clk, rst_n, ce, wr, rd, hot, busy, bank, rbusy;
   logic        ck, cke, cs_n, act_n, ras_n, cas_n, we_n;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic        in_pd, in_sr, low_cur, io_en, ca_en, odt_en, nom_en;
   logic        park_en, dll_en, rdy, abort;
   logic [1:0]  kind, rate;
   logic [15:0] rcount;
   int          n_errors, comparisons, n_abort, cycles;
   row_t rows[5] = '{'{2'h0, 1'b1, RATE_NORMAL}, '{2'h1, 1'b0, RATE_REDUCED},
      '{2'h2, 1'b0, RATE_HIGH}, '{2'h3, 1'b0, RATE_NORMAL},
      '{2'h3, 1'b1, RATE_HIGH}};

   ddr4_low_power_state_logic #(.CPDED_NCK(2), .XP_NCK(2), .XS_NCK(4),
      .XS_ABORT_NCK(2), .MPX_NCK(2)) uut (
      .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ck_i(ck),
      .cke_i(cke), .cs_n_i(cs_n), .act_n_i(act_n), .ras_n_i(ras_n),
      .cas_n_i(cas_n), .we_n_i(we_n), .temp_hot_i(hot), .op_busy_i(busy),
      .bank_open_i(bank), .refresh_busy_i(rbusy), .in_pd_o(in_pd),
      .in_sr_o(in_sr), .low_current_o(low_cur), .pd_kind_o(kind),
      .io_buf_en_o(io_en), .ca_rx_en_o(ca_en), .odt_buf_en_o(odt_en),
      .rtt_nom_en_o(nom_en), .rtt_park_en_o(park_en), .dll_en_o(dll_en),
      .cmd_ready_o(rdy), .sr_rate_o(rate), .refresh_abort_o(abort),
      .refresh_count_o(rcount));
   ctrl_model ctrl (.ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .act_n_o(act_n),
      .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic end_sim;
      $display("counts: %0d compared, %0d mismatched", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard; the whole run needs about 1000 cycles
   always @(posedge clk) begin
      cycles++;
      if (abort === 1'b1) n_abort++;
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", rdata, exp);
   endtask
   // sampler plus state pipeline is under eight core cycles
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic sr_enter;
      ctrl.link(1, 1'b1, 2'h0);
      ctrl.link(1, 1'b0, 2'h2);
      ctrl.link(2, 1'b0, 2'h0);
      settle();
   endtask

   initial begin
      {rst_n, wr, rd, hot, busy, bank, rbusy} = 7'h0;
      addr = 8'h00;
      ce = 1'b1;
      wdata = 32'h0;
      repeat (2) @(posedge clk);
      #1 chk("reset", {rdy, dll_en, park_en, io_en}, 4'b0101);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (rows[i]) begin
         wr_reg(8'h00, {24'h0, rows[i].sel, 6'h0});
         hot <= rows[i].hot;
         sr_enter();
         chk("in_sr", in_sr, 1'b1);
         chk("sr_rate", rate, rows[i].rate);
         chk("dll_en", dll_en, 1'b0);
         ctrl.link(7, 1'b1, 2'h0);
         settle();
         chk("sr_exit", {in_sr, rdy}, 2'b01);
         $display("sr row %0d done", i);
      end
      rd_chk(8'h00, 32'hc0);
      rd_chk(8'h10, 32'h0);
      // a write while the enable is low must not land
      ce <= 1'b0;
      wr_reg(8'h00, 32'h0);
      ce <= 1'b1;
      rd_chk(8'h00, 32'hc0);
      $display("clock enable test done");
      wr_reg(8'h04, 32'h200);
      rbusy <= 1'b1;
      sr_enter();
      ctrl.link(5, 1'b1, 2'h0);
      settle();
      chk("aborts", n_abort, 1);
      rbusy <= 1'b0;
      settle();
      chk("rcount", rcount, 16'h0);
      rbusy <= 1'b1;
      repeat (2) @(posedge clk);
      rbusy <= 1'b0;
      settle();
      chk("rcount", rcount, 16'h1);
      wr_reg(8'h04, 32'h0);
      $display("abort test done");
      sr_enter();
      ctrl.link(2, 1'b1, 2'h1);
      ctrl.link(4, 1'b1, 2'h0);
      settle();
      chk("nop_exit", {in_sr, rdy}, 2'b01);
      rd_chk(8'h0c, {8'h0, 16'h1, 1'b0, RATE_HIGH, 2'h0, 3'h0});
      // a no-op outside the window must raise the sticky flag
      sr_enter();
      ctrl.link(1, 1'b1, 2'h0);
      ctrl.link(1, 1'b1, 2'h1);
      ctrl.link(4, 1'b1, 2'h0);
      settle();
      rd_chk(8'h0c, {8'h0, 16'h1, 1'b1, RATE_HIGH, 2'h0, 3'h0});
      wr_reg(8'h0c, 32'h80);
      rd_chk(8'h0c, {8'h0, 16'h1, 1'b0, RATE_HIGH, 2'h0, 3'h0});
      $display("no-op exit test done");
      // open bank, register or burst work still pending at entry, dll locked
      bank <= 1'b1;
      busy <= 1'b1;
      ctrl.link(1, 1'b1, 2'h0);
      ctrl.link(2, 1'b0, 2'h0);
      settle();
      chk("pd_entry", {in_pd, io_en, ca_en, low_cur}, 4'b1010);
      ctrl.link(2, 1'b0, 2'h0);
      busy <= 1'b0;
      settle();
      chk("ca_rx_off", ca_en, 1'b0);
      chk("low_cur", low_cur, 1'b1);
      chk("kind", kind, PD_ACTIVE);
      chk("odt_dll", {odt_en, dll_en}, 2'b11);
      ctrl.link(1, 1'b1, 2'h0);
      settle();
      chk("exit_wait", rdy, 1'b0);
      ctrl.link(2, 1'b1, 2'h0);
      settle();
      chk("pd_exit", {in_pd, rdy}, 2'b01);
      $display("active power-down test done");
      wr_reg(8'h08, 32'h60);
      bank <= 1'b0;
      ctrl.link(1, 1'b1, 2'h0);
      ctrl.link(4, 1'b0, 2'h0);
      settle();
      chk("kind", kind, PD_PRECHARGE);
      chk("odt_off", {odt_en, nom_en}, 2'b00);
      chk("park", park_en, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      #1 chk("pd_reset", {in_pd, io_en}, 2'b01);
      $display("precharge power-down test done");
      end_sim();
   end
endmodule
